// ---- inc/mceh_pkg.sv ----
// Purpose: shared constants and types of the exposure handshake block
// Assumes: APB register slave, one clock, frame timing on a pin
// Notes:
// Function
// - one camera runs triggered-auto as master, the rest host-controlled.
// - at end of a frame with statistics the stale indication is cleared.
// - on fresh statistics the master computes a new log2 exposure target.
// - the target is split into integration time and gain and stored.
// - on storing a changed log2 value the master also sets its internal request flag.
// - at the next start of frame a pending request updates the sensor.
// - at the following end of frame, once applied, both flags clear.
// - the algorithm idles until the internal request flag is clear.
// - mode field bits 6 to 4: 0 auto, 1 triggered, 2 manual, 3 host.
// - the algorithm runs only on fresh statistics with the internal request flag clear.
package mceh_pkg;

	localparam logic [7:0]  MCEH_OFF_CTRL   = 8'h00;
	localparam logic [7:0]  MCEH_OFF_FLAGS  = 8'h04;
	localparam logic [7:0]  MCEH_OFF_INT    = 8'h08;
	localparam logic [7:0]  MCEH_OFF_GAIN   = 8'h0C;
	localparam logic [7:0]  MCEH_OFF_TARGET = 8'h10;
	localparam logic [7:0]  MCEH_OFF_STAT   = 8'h14;
	localparam logic [7:0]  MCEH_OFF_MASK   = 8'h18;
	localparam logic [7:0]  MCEH_OFF_LOG    = 8'h1C;

	localparam int          MCEH_MODE_LSB   = 4;
	localparam int          MCEH_MODE_MSB   = 6;
	localparam int          MCEH_FLG_INT    = 0;
	localparam int          MCEH_FLG_HOST   = 1;
	localparam int          MCEH_FLG_STALE  = 2;

	localparam int          MCEH_EV_W       = 4;
	localparam int          MCEH_EV_REQ     = 0;
	localparam int          MCEH_EV_APPLY   = 1;
	localparam int          MCEH_EV_FRESH   = 2;
	localparam int          MCEH_EV_HOSTREQ = 3;

	localparam logic [2:0]  MCEH_RST_MODE   = 3'h0;
	localparam logic [7:0]  MCEH_RST_TARGET = 8'h80;
	localparam logic [7:0]  MCEH_RST_LOG    = 8'h80;
	localparam logic [15:0] MCEH_RST_INT    = 16'h0100;
	localparam logic [7:0]  MCEH_RST_GAIN   = 8'h00;
	localparam logic [7:0]  MCEH_INT_LOG_MAX = 8'hA0;

	typedef enum logic [2:0] {
		MCEH_MODE_AUTO   = 3'h0,
		MCEH_MODE_TRIG   = 3'h1,
		MCEH_MODE_MANUAL = 3'h2,
		MCEH_MODE_HOST   = 3'h3
	} mceh_mode_t;

	typedef struct packed {
		logic [15:0] int_time;
		logic [7:0]  gain_log;
	} mceh_exp_t;

endpackage : mceh_pkg

// ---- core/mceh_log2.sv ----
// Purpose: registered log2 of an unsigned value, integer.fraction format
// Assumes: W up to 16, so the integer part fits four bits
// Notes: zero input reads as zero
`timescale 1ns/100ps
`default_nettype none
module mceh_log2 #(
	parameter int W = 16,
	parameter int F = 4
) (
	input  wire logic           clk,    // clock
	input  wire logic           rst_n,  // async reset, active low
	input  wire logic [W-1:0]   val,    // value to convert
	output logic      [3+F:0]   log_q   // log2, four integer bits
);
	logic [3:0]   msb;
	logic [W-1:0] norm;
	logic [3+F:0] log_d;

	always_comb begin
		msb = 4'h0;
		for (int i = 0; i < W; i++) begin
			if (val[i]) begin
				msb = i[3:0];
			end
		end
		norm  = val << (4'(W - 1) - msb);
		log_d = {msb, norm[W-2 -: F]};
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			log_q <= '0;
		end else begin
			log_q <= log_d;
		end
	end
endmodule : mceh_log2
`default_nettype wire

// ---- core/mceh_top.sv ----
// Purpose: exposure request handshake of one camera, master or slave
// Assumes: frame_valid_pin is asynchronous; stats and sensor on pclk
// Notes: APB slave with no wait states, registered read data
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module mceh_top
	import mceh_pkg::*;
#(
	parameter logic [7:0] INT_LOG_MAX = MCEH_INT_LOG_MAX
) (
	input  wire logic        pclk,            // clock, 200 MHz
	input  wire logic        presetn,         // async reset, active low
	input  wire logic [7:0]  paddr,           // apb byte address
	input  wire logic        psel,            // apb select
	input  wire logic        penable,         // apb enable
	input  wire logic        pwrite,          // apb direction
	input  wire logic [31:0] pwdata,          // apb write data
	output logic      [31:0] prdata,          // apb read data
	output logic             pready,          // apb ready
	output logic             pslverr,         // apb error, unmapped
	input  wire logic        frame_valid_pin, // frame valid, async
	input  wire logic        stats_valid,     // statistics sample strobe
	input  wire logic [15:0] stats_mean,      // statistics mean level
	input  wire logic        exp_done,        // sensor confirms change
	output logic             sensor_update,   // apply pulse to sensor
	output mceh_exp_t        sensor_exp,      // settings applied
	output logic             is_master,       // triggered-auto role
	output logic             irq              // level interrupt
);
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_MEAS  = 4'b0010,
		ST_SPLIT = 4'b0100,
		ST_WRITE = 4'b1000
	} mceh_st_t;

	logic [2:0]  fv_s;
	logic        sof_p, eof_p;
	logic [7:0]  meas_log;

	mceh_st_t    state_q, state_d;
	logic [2:0]  mode_q, mode_d;
	logic        int_req_q, int_req_d, host_req_q, host_req_d;
	logic        stale_q, stale_d, seen_q, seen_d;
	logic        applied_q, applied_d, done_q, done_d;
	logic [15:0] stats_q, stats_d, exp_int_q, exp_int_d;
	logic [7:0]  gain_q, gain_d, target_q, target_d, log_q, log_d;
	logic [7:0]  new_log_q, new_log_d, int_log_q, int_log_d;
	logic [MCEH_EV_W-1:0] stat_q, stat_d, mask_q, mask_d, ev;
	logic        upd_q, upd_d, master_q, master_d, irq_q, irq_d;
	mceh_exp_t   sexp_q, sexp_d;
	logic [31:0] rdata_q, rdata_d;
	logic        rdy_q, rdy_d, err_q, err_d;

	logic        wr_en, setup, hit, pend, algo_en, fresh_now;
	logic signed [8:0] err_l, step;
	logic signed [9:0] sum;
	logic [19:0] lin;

	// frame edges from the synchronised pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fv_s <= 3'h0;
		end else begin
			fv_s <= {fv_s[1:0], frame_valid_pin};
		end
	end
	assign sof_p = fv_s[1] & ~fv_s[2];
	assign eof_p = ~fv_s[1] & fv_s[2];

	mceh_log2 #(.W(16), .F(4)) u_log2 (
		.clk   (pclk),
		.rst_n (presetn),
		.val   (stats_q),
		.log_q (meas_log)
	);

	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pwrite & rdy_q;
	assign hit   = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);

	always_comb begin
		rdata_d = 32'h0000_0000;
		rdy_d   = setup;
		err_d   = setup & ~hit;
		if (setup) begin
			unique case (paddr)
				MCEH_OFF_CTRL:   rdata_d[MCEH_MODE_MSB:MCEH_MODE_LSB] = mode_q;
				MCEH_OFF_FLAGS:  rdata_d[2:0] = {stale_q, host_req_q, int_req_q};
				MCEH_OFF_INT:    rdata_d[15:0] = exp_int_q;
				MCEH_OFF_GAIN:   rdata_d[7:0] = gain_q;
				MCEH_OFF_TARGET: rdata_d[7:0] = target_q;
				MCEH_OFF_STAT:   rdata_d[MCEH_EV_W-1:0] = stat_q;
				MCEH_OFF_MASK:   rdata_d[MCEH_EV_W-1:0] = mask_q;
				MCEH_OFF_LOG:    rdata_d[7:0] = log_q;
				default:         rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_comb begin
		state_d    = state_q;
		mode_d     = mode_q;
		int_req_d  = int_req_q;
		host_req_d = host_req_q;
		stale_d    = stale_q;
		seen_d     = seen_q | stats_valid;
		applied_d  = applied_q;
		done_d     = done_q | (applied_q & exp_done);
		stats_d    = stats_valid ? stats_mean : stats_q;
		exp_int_d  = exp_int_q;
		gain_d     = gain_q;
		target_d   = target_q;
		log_d      = log_q;
		new_log_d  = new_log_q;
		int_log_d  = int_log_q;
		mask_d     = mask_q;
		upd_d      = 1'b0;
		sexp_d     = sexp_q;
		ev         = '0;
		algo_en    = (mode_q == MCEH_MODE_AUTO) || (mode_q == MCEH_MODE_TRIG);
		master_d   = (mode_q == MCEH_MODE_TRIG);
		// auto mode applies its own request, all others wait for the host
		pend       = host_req_q | ((mode_q == MCEH_MODE_AUTO) & int_req_q);
		fresh_now  = 1'b0;
		err_l = $signed({1'b0, target_q}) - $signed({1'b0, meas_log});
		step  = err_l >>> 1;
		sum   = $signed({2'b00, log_q}) + $signed({step[8], step});
		lin   = {15'h0000, 1'b1, int_log_q[3:0]} << int_log_q[7:4];

		if (wr_en) begin
			unique case (paddr)
				MCEH_OFF_CTRL: begin
					mode_d = pwdata[MCEH_MODE_MSB:MCEH_MODE_LSB];
				end
				MCEH_OFF_FLAGS: begin
					int_req_d  = pwdata[MCEH_FLG_INT];
					host_req_d = pwdata[MCEH_FLG_HOST];
					ev[MCEH_EV_HOSTREQ] = pwdata[MCEH_FLG_HOST] & ~host_req_q;
				end
				MCEH_OFF_INT:    exp_int_d = pwdata[15:0];
				MCEH_OFF_GAIN:   gain_d    = pwdata[7:0];
				MCEH_OFF_TARGET: target_d  = pwdata[7:0];
				MCEH_OFF_MASK:   mask_d    = pwdata[MCEH_EV_W-1:0];
				default:         mask_d    = mask_q;
			endcase
		end

		if (eof_p && seen_q) begin
			stale_d   = 1'b0;
			seen_d    = stats_valid;
			fresh_now = 1'b1;
			ev[MCEH_EV_FRESH] = 1'b1;
		end

		if (sof_p && pend) begin
			upd_d     = 1'b1;
			sexp_d    = '{int_time: exp_int_q, gain_log: gain_q};
			applied_d = 1'b1;
			done_d    = 1'b0;
		end

		if (eof_p && applied_q && (done_q || exp_done)) begin
			int_req_d  = 1'b0;
			host_req_d = 1'b0;
			applied_d  = 1'b0;
			done_d     = 1'b0;
			ev[MCEH_EV_APPLY] = 1'b1;
		end

		unique case (state_q)
			ST_IDLE: begin
				if (algo_en && !stale_q && !int_req_q) begin
					state_d = ST_MEAS;
				end
			end
			ST_MEAS: begin
				if (sum < 0) begin
					new_log_d = 8'h00;
				end else if (sum > 10'sd255) begin
					new_log_d = 8'hFF;
				end else begin
					new_log_d = sum[7:0];
				end
				if (!fresh_now) begin
					stale_d = 1'b1;
				end
				state_d = ST_SPLIT;
			end
			ST_SPLIT: begin
				int_log_d = (new_log_q > INT_LOG_MAX) ? INT_LOG_MAX
				          : new_log_q;
				state_d   = ST_WRITE;
			end
			ST_WRITE: begin
				exp_int_d = lin[19:4];
				gain_d    = new_log_q - int_log_q;
				log_d     = new_log_q;
				if (new_log_q != log_q) begin
					int_req_d = 1'b1;
					ev[MCEH_EV_REQ] = 1'b1;
				end
				state_d = ST_IDLE;
			end
		endcase

		stat_d = stat_q;
		if (wr_en && paddr == MCEH_OFF_STAT) begin
			stat_d = stat_q & ~pwdata[MCEH_EV_W-1:0];
		end
		stat_d = stat_d | ev;
		irq_d  = |(stat_d & mask_d);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q    <= ST_IDLE;
			mode_q     <= MCEH_RST_MODE;
			int_req_q  <= 1'b0;
			host_req_q <= 1'b0;
			stale_q    <= 1'b1;
			seen_q     <= 1'b0;
			applied_q  <= 1'b0;
			done_q     <= 1'b0;
			stats_q    <= 16'h0000;
			exp_int_q  <= MCEH_RST_INT;
			gain_q     <= MCEH_RST_GAIN;
			target_q   <= MCEH_RST_TARGET;
			log_q      <= MCEH_RST_LOG;
			new_log_q  <= MCEH_RST_LOG;
			int_log_q  <= 8'h00;
			stat_q     <= '0;
			mask_q     <= '0;
			upd_q      <= 1'b0;
			sexp_q     <= '0;
			master_q   <= 1'b0;
			irq_q      <= 1'b0;
			rdata_q    <= 32'h0000_0000;
			rdy_q      <= 1'b0;
			err_q      <= 1'b0;
		end else begin
			state_q    <= state_d;
			mode_q     <= mode_d;
			int_req_q  <= int_req_d;
			host_req_q <= host_req_d;
			stale_q    <= stale_d;
			seen_q     <= seen_d;
			applied_q  <= applied_d;
			done_q     <= done_d;
			stats_q    <= stats_d;
			exp_int_q  <= exp_int_d;
			gain_q     <= gain_d;
			target_q   <= target_d;
			log_q      <= log_d;
			new_log_q  <= new_log_d;
			int_log_q  <= int_log_d;
			stat_q     <= stat_d;
			mask_q     <= mask_d;
			upd_q      <= upd_d;
			sexp_q     <= sexp_d;
			master_q   <= master_d;
			irq_q      <= irq_d;
			rdata_q    <= rdata_d;
			rdy_q      <= rdy_d;
			err_q      <= err_d;
		end
	end

	assign prdata        = rdata_q;
	assign pready        = rdy_q;
	assign pslverr       = err_q;
	assign sensor_update = upd_q;
	assign sensor_exp    = sexp_q;
	assign is_master     = master_q;
	assign irq           = irq_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic flag_wr;
	assign flag_wr = wr_en && (paddr == MCEH_OFF_FLAGS);

	sequence s_compute;
		state_q == ST_MEAS ##1 state_q == ST_SPLIT ##1 state_q == ST_WRITE;
	endsequence

	a_master_role: assert property (##1
		master_q == ($past(mode_q) == MCEH_MODE_TRIG))
		else $error("master role does not follow mode");
	a_stale_clear: assert property (eof_p && seen_q |=> !stale_q)
		else $error("stale not cleared at end of frame");
	a_compute_run: assert property (state_q == ST_IDLE ##1 state_q == ST_MEAS
		|-> ##1 state_q == ST_SPLIT ##1 state_q == ST_WRITE ##1 state_q == ST_IDLE)
		else $error("compute sequence broken");
	a_split_store: assert property (s_compute |=>
		{4'h0, exp_int_q} == ($past(lin) >> 4)
		&& gain_q == $past(new_log_q) - $past(int_log_q))
		else $error("exposure values not stored");
	a_req_set: assert property (s_compute ##0 new_log_q != log_q |=> int_req_q)
		else $error("request flag not set after update");
	a_settled_quiet: assert property (s_compute ##0 new_log_q == log_q
		&& !int_req_q && !flag_wr |=> !int_req_q)
		else $error("request set for unchanged exposure");
	a_algo_gate: assert property (state_q == ST_IDLE ##1 state_q == ST_MEAS
		|-> !$past(stale_q) && !$past(int_req_q) && $past(algo_en))
		else $error("algorithm started while gated");
	a_apply_sof: assert property (sof_p && pend |=> sensor_update
		&& sensor_exp.int_time == $past(exp_int_q))
		else $error("pending request not applied at frame start");
	a_apply_only_sof: assert property ($rose(sensor_update) |-> $past(sof_p))
		else $error("sensor update outside frame start");
	a_flags_clear: assert property (eof_p && applied_q && (done_q || exp_done)
		&& state_q != ST_WRITE && !flag_wr |=> !int_req_q && !host_req_q)
		else $error("flags not cleared after applied change");
	a_apb_answer: assert property (setup |=> pready ##1 !pready || setup)
		else $error("apb answer timing wrong");
endmodule : mceh_top
`default_nettype wire

// ---- tb/mceh_sensor_model.sv ----
// Purpose: sensor and frame source on the far side of the block
// Assumes: bench sets frame_on and mean; one clock
// Notes: stats_mean shows the inverse of mean outside its strobe
`timescale 1ns/100ps
`default_nettype none
module mceh_sensor_model #(
	parameter int LAT = 3
) (
	input  wire logic        pclk,            // clock
	input  wire logic        presetn,         // async reset, active low
	input  wire logic        frame_on,        // bench frame request
	input  wire logic [15:0] mean,            // mean for this frame
	input  wire logic        sensor_update,   // apply pulse from block
	output logic             frame_valid_pin, // frame valid
	output logic             stats_valid,     // statistics strobe
	output logic      [15:0] stats_mean,      // statistics value
	output logic             exp_done         // change taken effect
);
	int cnt;
	int dly;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			dly <= 0;
			frame_valid_pin <= 1'b0;
			stats_valid <= 1'b0;
			stats_mean <= 16'h0000;
			exp_done <= 1'b0;
		end else begin
			frame_valid_pin <= frame_on;
			cnt <= frame_on ? cnt + 1 : 0;
			stats_valid <= frame_on && cnt == 4;
			stats_mean <= (frame_on && cnt == 4) ? mean : ~mean;
			// sensor confirms a change some cycles after it is applied
			dly <= sensor_update ? LAT : (dly > 0 ? dly - 1 : 0);
			exp_done <= dly == 1;
		end
	end
endmodule : mceh_sensor_model
`default_nettype wire

// ---- tb/mceh_top_tb.sv ----
// Purpose: self-checking bench of the exposure handshake block
// Assumes: bench plays the host over apb, model plays the sensor
// Notes: expected values come from an integer model of the algorithm
`timescale 1ns/100ps
`default_nettype none
module mceh_top_tb
	import mceh_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, frame_on;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, v;
	logic        pready, pslverr, er, irq, is_master;
	logic        frame_valid_pin, stats_valid, exp_done, sensor_update;
	logic [15:0] stats_mean, mean;
	mceh_exp_t   sensor_exp, seen_exp;
	logic [23:0] sx;
	int          miscompares, n_tests, n_upd, m_log, i;
	logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C,
		8'h10, 8'h14, 8'h18, 8'h1C};
	logic [31:0] rv [8] = '{32'h0, 32'h4, 32'h100, 32'h0,
		32'h80, 32'h0, 32'h0, 32'h80};

	mceh_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .frame_valid_pin(frame_valid_pin),
		.stats_valid(stats_valid), .stats_mean(stats_mean),
		.exp_done(exp_done), .sensor_update(sensor_update),
		.sensor_exp(sensor_exp), .is_master(is_master), .irq(irq));
	mceh_sensor_model #(.LAT(3)) sensor (.pclk(pclk),
		.presetn(presetn), .frame_on(frame_on), .mean(mean),
		.sensor_update(sensor_update),
		.frame_valid_pin(frame_valid_pin), .stats_valid(stats_valid),
		.stats_mean(stats_mean), .exp_done(exp_done));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (sensor_update === 1'b1) begin
			n_upd++;
			seen_exp = sensor_exp;
		end
	end

	function automatic int exp_log(int lg, int tg, int lm);
		int n;
		n = lg + ((tg - lm) >>> 1);
		return n < 0 ? 0 : (n > 255 ? 255 : n);
	endfunction : exp_log
	function automatic int lg2(int m);
		int k;
		k = $clog2(m + 1) - 1;
		return k * 16 + (((m << (15 - k)) >> 11) % 16);
	endfunction : lg2
	function automatic logic [23:0] split(int n);
		int il;
		il = n < MCEH_INT_LOG_MAX ? n : MCEH_INT_LOG_MAX;
		split[23:8] = 16'(((16 + il % 16) << (il / 16)) >> 4);
		split[7:0] = 8'(n - il);
	endfunction : split

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rdc
	task sof(input logic [15:0] m);
		@(posedge pclk);
		mean <= m;
		frame_on <= 1'b1;
		repeat (12) @(posedge pclk);
	endtask : sof
	task eof;
		@(posedge pclk);
		frame_on <= 1'b0;
		repeat (30) @(posedge pclk);
	endtask : eof
	task wrap_up;
		$display("tests=%0d miscompares=%0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up

	initial begin
		#60000;
		miscompares++;
		wrap_up();
	end

	initial begin
		{psel, penable, pwrite, frame_on, presetn} = 5'h0;
		{paddr, pwdata, mean} = 56'h0;
		{miscompares, n_tests, n_upd} = 96'h0;
		void'($urandom(32'h1B3DBC8A));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 8; i++) rdc(ra[i], rv[i]);
		apb(1'b0, 8'h20, 32'h0);
		chk(er, 1'b1);
		$display("test reset done");
		for (i = 0; i < 4; i++) begin
			apb(1'b1, MCEH_OFF_CTRL, 32'(i) << MCEH_MODE_LSB);
			repeat (2) @(posedge pclk);
			chk(is_master, i == 1);
			rdc(MCEH_OFF_CTRL, 32'(i) << MCEH_MODE_LSB);
		end
		$display("test modes done");
		v = $urandom;
		apb(1'b1, MCEH_OFF_INT, v);
		rdc(MCEH_OFF_INT, v & 32'hFFFF);
		apb(1'b1, MCEH_OFF_GAIN, v);
		rdc(MCEH_OFF_GAIN, v & 32'hFF);
		apb(1'b1, MCEH_OFF_FLAGS, 32'h3);
		rdc(MCEH_OFF_FLAGS, 32'h7);
		apb(1'b1, MCEH_OFF_FLAGS, 32'h0);
		rdc(MCEH_OFF_FLAGS, 32'h4);
		$display("test access done");
		apb(1'b1, MCEH_OFF_CTRL, 32'h10);
		apb(1'b1, MCEH_OFF_TARGET, 32'hA0);
		apb(1'b1, MCEH_OFF_MASK, 32'h3);
		m_log = exp_log(32'h80, 32'hA0, lg2(32'h100));
		sx = split(m_log);
		sof(16'h0100);
		eof();
		rdc(MCEH_OFF_FLAGS, 32'h5);
		rdc(MCEH_OFF_LOG, 32'(m_log));
		rdc(MCEH_OFF_INT, 32'(sx[23:8]));
		rdc(MCEH_OFF_GAIN, 32'(sx[7:0]));
		chk(irq, 1'b1);
		apb(1'b1, MCEH_OFF_STAT, 32'h1);
		repeat (3) @(posedge pclk);
		chk(irq, 1'b0);
		$display("test algorithm done");
		sof(16'h0040);
		eof();
		rdc(MCEH_OFF_LOG, 32'(m_log));
		rdc(MCEH_OFF_FLAGS, 32'h1);
		$display("test idle done");
		sof(16'h0200);
		rdc(MCEH_OFF_FLAGS, 32'h1);
		rdc(MCEH_OFF_INT, 32'(sx[23:8]));
		apb(1'b1, MCEH_OFF_FLAGS, 32'h3);
		eof();
		chk(n_upd, 0);
		sof(16'h0400);
		chk(n_upd, 1);
		chk(seen_exp, split(m_log));
		eof();
		apb(1'b0, MCEH_OFF_FLAGS, 32'h0);
		chk(rd[1:0], 2'h0);
		chk(irq, 1'b1);
		apb(1'b1, MCEH_OFF_STAT, 32'h2);
		repeat (3) @(posedge pclk);
		chk(irq, 1'b0);
		$display("test handshake done");
		sof(16'h0400);
		eof();
		apb(1'b0, MCEH_OFF_FLAGS, 32'h0);
		chk(rd[1:0], 2'h0);
		m_log = exp_log(m_log, 32'hA0, lg2(32'h400));
		rdc(MCEH_OFF_LOG, 32'(m_log));
		chk(n_upd, 1);
		$display("test settled done");
		v = $urandom;
		apb(1'b1, MCEH_OFF_CTRL, 32'h30);
		apb(1'b1, MCEH_OFF_INT, v);
		apb(1'b1, MCEH_OFF_GAIN, v >> 8);
		apb(1'b1, MCEH_OFF_FLAGS, 32'h2);
		sof(16'h0100);
		chk(n_upd, 2);
		chk(seen_exp, {v[15:0], v[15:8]});
		eof();
		rdc(MCEH_OFF_FLAGS, 32'h0);
		rdc(MCEH_OFF_LOG, 32'(m_log));
		$display("test slave done");
		apb(1'b1, MCEH_OFF_CTRL, 32'h00);
		m_log = exp_log(m_log, 32'hA0, lg2(32'h100));
		sx = split(m_log);
		sof(16'h0400);
		chk(n_upd, 3);
		chk(seen_exp, sx);
		eof();
		m_log = exp_log(m_log, 32'hA0, lg2(32'h400));
		rdc(MCEH_OFF_FLAGS, 32'h4);
		rdc(MCEH_OFF_LOG, 32'(m_log));
		$display("test auto done");
		wrap_up();
	end
endmodule : mceh_top_tb
`default_nettype wire
